// ### logic/sier_regs.sv
/*
 * Per-port internal error register bank with an AXI4-Lite slave, parity error
 * flag, saturating read-clear counter, time-out control and error messages.
 * Assumes parity errors arrive as one-cycle pulses and the time-out status
 * bits are levels from the time-out status register outside this block.
 */
// Local design decision: the AXI4-Lite interface to the registers.
// Overview of operation
// [RQ1] Parity error sets status bit 0; writing one clears it.
// [RQ2] Parity report field selects none, correctable, nonfatal or fatal message.
// [RQ3] Parity message goes out only when the status flag rises.
// [RQ4] Parity report field resets to nonfatal.
// [RQ5] With interrupt enable and upstream interrupts on, parity error issues an interrupt TLP.
// [RQ6] Eight-bit parity error counter increments per error, holding at 0xFF.
// [RQ7] Reading the counter returns its value then clears it.
// [RQ8] With time-out enable set, expired TLPs in the input queue are discarded.
// [RQ9] Time-out enable resets to one.
// [RQ10] Posted time-out report field in bits 1:0 resets to nonfatal.
// [RQ11] Non-posted time-out report field in bits 3:2 resets to none.
// [RQ12] Completion time-out report field in bits 5:4 resets to none.
// [RQ13] Time-out message goes out only when that class's status bit rises.
// [RQ14] Reserved bits read zero; an error during a counter read still counts.
`timescale 1ns/1ps
module sier_regs
    import sier_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic parity_err_i,
    input wire logic [2:0] timeout_status_i,
    input wire logic upstream_int_en_i,
    input wire logic queue_head_expired_i,
    output logic discard_tlp_o,
    output logic int_tlp_o,
    output logic err_cor_o,
    output logic err_nonfatal_o,
    output logic err_fatal_o,
    output logic irq_o
);

    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
        reg_hit = (addr[11:2] == off[11:2]);
    endfunction

    // Bus state.
    logic aw_hold_q;
    logic [11:0] aw_addr_q;
    logic w_hold_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Register state.
    logic parity_err_flag_q;
    logic parity_err_flag_d;
    logic [1:0] par_rep_q;
    logic parity_err_irq_en_q;
    logic [7:0] parity_err_tally_q;
    logic [7:0] parity_err_tally_d;
    logic queue_timeout_en_q;
    logic [1:0] posted_timeout_report_q;
    logic [1:0] nonposted_timeout_report_q;
    logic [1:0] completion_timeout_report_q;
    logic irq_mask_q;
    logic int_tlp_q;
    logic err_cor_q;
    logic err_nonfatal_q;
    logic err_fatal_q;

    // Write path decode.
    logic do_write_w;
    logic wr_lane0_w;
    logic wr_sts_w;
    logic wr_ctl_w;
    logic wr_to_w;
    logic wr_rctl_w;
    logic wr_mask_w;
    logic wr_mapped_w;
    logic sts_clr_w;

    assign s_axi_awready_o = ~aw_hold_q;
    assign s_axi_wready_o = ~w_hold_q;
    assign do_write_w = aw_hold_q & w_hold_q & ~bvalid_q;
    assign wr_lane0_w = do_write_w & w_strb_q[0];
    assign wr_sts_w = wr_lane0_w & reg_hit(aw_addr_q, OFF_ERR_STS);
    assign wr_ctl_w = wr_lane0_w & reg_hit(aw_addr_q, OFF_ERR_CTL);
    assign wr_to_w = wr_lane0_w & reg_hit(aw_addr_q, OFF_TO_CTL);
    assign wr_rctl_w = wr_lane0_w & reg_hit(aw_addr_q, OFF_TO_RCTL);
    assign wr_mask_w = wr_lane0_w & reg_hit(aw_addr_q, OFF_IRQ_MASK);
    assign wr_mapped_w = reg_hit(aw_addr_q, OFF_ERR_STS) | reg_hit(aw_addr_q, OFF_ERR_CTL)
        | reg_hit(aw_addr_q, OFF_ERR_CNT) | reg_hit(aw_addr_q, OFF_TO_CTL)
        | reg_hit(aw_addr_q, OFF_TO_RCTL) | reg_hit(aw_addr_q, OFF_IRQ_MASK);
    assign sts_clr_w = wr_sts_w & w_data_q[STS_PAR_BIT];

    // Read path decode.
    logic rd_take_w;
    logic rd_cnt_w;
    logic rd_mapped_w;
    logic [31:0] rd_sts_w;
    logic [31:0] rd_ctl_w;
    logic [31:0] rd_cnt_val_w;
    logic [31:0] rd_to_w;
    logic [31:0] rd_rctl_w;
    logic [31:0] rd_mask_w;
    logic [31:0] rd_mux_w;

    assign s_axi_arready_o = ~rvalid_q;
    assign rd_take_w = s_axi_arvalid_i & ~rvalid_q;
    assign rd_cnt_w = rd_take_w & reg_hit(s_axi_araddr_i, OFF_ERR_CNT);
    // Reserved bits are padded with zero. [RQ14]
    assign rd_sts_w = {31'h0000_0000, parity_err_flag_q};
    assign rd_ctl_w = {29'h0000_0000, parity_err_irq_en_q, par_rep_q};
    assign rd_cnt_val_w = {24'h00_0000, parity_err_tally_q};
    assign rd_to_w = {31'h0000_0000, queue_timeout_en_q};
    assign rd_rctl_w = {26'h000_0000, completion_timeout_report_q, nonposted_timeout_report_q,
        posted_timeout_report_q};
    assign rd_mask_w = {31'h0000_0000, irq_mask_q};
    assign rd_mapped_w = reg_hit(s_axi_araddr_i, OFF_ERR_STS) | reg_hit(s_axi_araddr_i, OFF_ERR_CTL)
        | reg_hit(s_axi_araddr_i, OFF_ERR_CNT) | reg_hit(s_axi_araddr_i, OFF_TO_CTL)
        | reg_hit(s_axi_araddr_i, OFF_TO_RCTL) | reg_hit(s_axi_araddr_i, OFF_IRQ_MASK);
    assign rd_mux_w = reg_hit(s_axi_araddr_i, OFF_ERR_STS) ? rd_sts_w :
        reg_hit(s_axi_araddr_i, OFF_ERR_CTL) ? rd_ctl_w :
        reg_hit(s_axi_araddr_i, OFF_ERR_CNT) ? rd_cnt_val_w :
        reg_hit(s_axi_araddr_i, OFF_TO_CTL) ? rd_to_w :
        reg_hit(s_axi_araddr_i, OFF_TO_RCTL) ? rd_rctl_w :
        reg_hit(s_axi_araddr_i, OFF_IRQ_MASK) ? rd_mask_w : 32'h0000_0000;

    // Write address and data are taken in either order, then answered together.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_hold_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && !aw_hold_q) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_i;
            end else if (do_write_w) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid_i && !w_hold_q) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
            end else if (do_write_w) begin
                w_hold_q <= 1'b0;
            end
            if (do_write_w) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped_w ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (rd_take_w) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux_w;
            rresp_q <= rd_mapped_w ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;

    // A new error wins over a clear in the same cycle. [RQ1]
    assign parity_err_flag_d = parity_err_i | (parity_err_flag_q & ~sts_clr_w);

    // Read clears first, then an error in the same cycle still counts. [RQ6] [RQ7] [RQ14]
    logic [7:0] tally_base_w;
    assign tally_base_w = rd_cnt_w ? CNT_ZERO : parity_err_tally_q;
    assign parity_err_tally_d = (parity_err_i && tally_base_w != CNT_MAX) ? tally_base_w + CNT_ONE
        : tally_base_w;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            parity_err_flag_q <= 1'b0;
            parity_err_tally_q <= CNT_ZERO;
            irq_mask_q <= MASK_RST;
        end else begin
            parity_err_flag_q <= parity_err_flag_d;
            parity_err_tally_q <= parity_err_tally_d;
            if (wr_mask_w) begin
                irq_mask_q <= w_data_q[STS_PAR_BIT];
            end
        end
    end

    // Control fields come out of reset at their documented values. [RQ4] [RQ9] [RQ10] [RQ11] [RQ12]
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            par_rep_q <= PAR_REP_RST;
            parity_err_irq_en_q <= IRQ_EN_RST;
            queue_timeout_en_q <= TO_EN_RST;
            posted_timeout_report_q <= POST_REP_RST;
            nonposted_timeout_report_q <= NP_REP_RST;
            completion_timeout_report_q <= CPL_REP_RST;
        end else begin
            if (wr_ctl_w) begin
                par_rep_q <= w_data_q[CTL_REP_HI:CTL_REP_LO];
                parity_err_irq_en_q <= w_data_q[CTL_IRQ_BIT];
            end
            if (wr_to_w) begin
                queue_timeout_en_q <= w_data_q[TO_EN_BIT];
            end
            if (wr_rctl_w) begin
                posted_timeout_report_q <= w_data_q[RCTL_POST_HI:RCTL_POST_LO];
                nonposted_timeout_report_q <= w_data_q[RCTL_NP_HI:RCTL_NP_LO];
                completion_timeout_report_q <= w_data_q[RCTL_CPL_HI:RCTL_CPL_LO];
            end
        end
    end

    // Message sources: parity flag, then posted, non-posted and completion time-outs.
    logic [NUM_SRC-1:0] src_flag_w;
    logic [1:0] src_field_w [NUM_SRC];
    logic [NUM_SRC-1:0] msg_v_w;
    logic [1:0] msg_t_w [NUM_SRC];
    logic [NUM_SRC-1:0] is_cor_w;
    logic [NUM_SRC-1:0] is_nonfatal_w;
    logic [NUM_SRC-1:0] is_fatal_w;

    assign src_flag_w = {timeout_status_i, parity_err_flag_q};
    assign src_field_w[0] = par_rep_q;
    assign src_field_w[1] = posted_timeout_report_q;
    assign src_field_w[2] = nonposted_timeout_report_q;
    assign src_field_w[3] = completion_timeout_report_q;

    // Each source reports on its own rising edge with its own type. [RQ2] [RQ3] [RQ13]
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        sier_reporter u_rep (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .flag_i(src_flag_w[i]),
            .field_i(src_field_w[i]),
            .msg_valid_o(msg_v_w[i]),
            .msg_type_o(msg_t_w[i])
        );
        assign is_cor_w[i] = msg_v_w[i] && msg_t_w[i] == REP_COR;
        assign is_nonfatal_w[i] = msg_v_w[i] && msg_t_w[i] == REP_NONFATAL;
        assign is_fatal_w[i] = msg_v_w[i] && msg_t_w[i] == REP_FATAL;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            err_cor_q <= 1'b0;
            err_nonfatal_q <= 1'b0;
            err_fatal_q <= 1'b0;
            int_tlp_q <= 1'b0;
        end else begin
            err_cor_q <= |is_cor_w;
            err_nonfatal_q <= |is_nonfatal_w;
            err_fatal_q <= |is_fatal_w;
            int_tlp_q <= parity_err_i & parity_err_irq_en_q & upstream_int_en_i; // [RQ5]
        end
    end

    assign err_cor_o = err_cor_q;
    assign err_nonfatal_o = err_nonfatal_q;
    assign err_fatal_o = err_fatal_q;
    assign int_tlp_o = int_tlp_q;
    assign discard_tlp_o = queue_head_expired_i & queue_timeout_en_q; // [RQ8]
    assign irq_o = parity_err_flag_q & irq_mask_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_flag_sets: assert property ( // [RQ1]
        parity_err_i |=> parity_err_flag_q)
        else $error("Parity error did not set the status flag.");

    a_flag_clears: assert property ( // [RQ1]
        parity_err_flag_q && sts_clr_w && !parity_err_i |=> !parity_err_flag_q)
        else $error("Write of one did not clear the status flag.");

    a_par_cor_msg: assert property ( // [RQ2]
        $rose(parity_err_flag_q) && par_rep_q == REP_COR |=> err_cor_o)
        else $error("Correctable parity report missing.");

    a_par_once: assert property ( // [RQ3]
        msg_v_w[0] |-> $rose(parity_err_flag_q))
        else $error("Parity message without a rising flag.");

    a_ctl_reset: assert property ( // [RQ4]
        $past(rst_i) |-> par_rep_q == REP_NONFATAL)
        else $error("Parity report field reset value wrong.");

    a_int_tlp_gate: assert property ( // [RQ5]
        parity_err_i && parity_err_irq_en_q && upstream_int_en_i |=> int_tlp_o)
        else $error("Interrupt TLP missing after parity error.");

    a_int_tlp_quiet: assert property ( // [RQ5]
        !(parity_err_i && parity_err_irq_en_q && upstream_int_en_i) |=> !int_tlp_o)
        else $error("Interrupt TLP issued without an enabled parity error.");

    a_tally_incr: assert property ( // [RQ6]
        parity_err_i && !rd_cnt_w && parity_err_tally_q != CNT_MAX
        |=> parity_err_tally_q == $past(parity_err_tally_q) + CNT_ONE)
        else $error("Counter did not increment.");

    a_tally_sat: assert property ( // [RQ6]
        parity_err_tally_q == CNT_MAX && !rd_cnt_w |=> parity_err_tally_q == CNT_MAX)
        else $error("Counter wrapped past its maximum.");

    a_tally_rdclr: assert property ( // [RQ7]
        rd_cnt_w |=> s_axi_rdata_o[CNT_HI:0] == $past(parity_err_tally_q)
            && parity_err_tally_q == ($past(parity_err_i) ? CNT_ONE : CNT_ZERO))
        else $error("Counter read did not return and clear.");

    a_discard_gate: assert property ( // [RQ8]
        !queue_timeout_en_q |-> !discard_tlp_o)
        else $error("TLP discarded with time-outs disabled.");

    a_to_reset: assert property ( // [RQ9]
        $past(rst_i) |-> queue_timeout_en_q && posted_timeout_report_q == REP_NONFATAL
            && nonposted_timeout_report_q == REP_NONE && completion_timeout_report_q == REP_NONE)
        else $error("Time-out control reset values wrong.");

    a_to_fatal_msg: assert property ( // [RQ13]
        $rose(timeout_status_i[0]) && posted_timeout_report_q == REP_FATAL |=> err_fatal_o)
        else $error("Posted time-out fatal report missing.");

    a_resv_zero: assert property ( // [RQ14]
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
        else $error("Reserved read bits not zero.");

endmodule

// ### logic/sier_pkg.sv
/*
 * Constants for the per-port internal error register bank: register offsets,
 * field positions, reset values and the error message encoding.
 * Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
 */
package sier_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_SRC = 4;

    localparam logic [11:0] OFF_ERR_STS = 12'h4D8;
    localparam logic [11:0] OFF_ERR_CTL = 12'h4DC;
    localparam logic [11:0] OFF_ERR_CNT = 12'h4E0;
    localparam logic [11:0] OFF_TO_CTL = 12'h4E4;
    localparam logic [11:0] OFF_TO_RCTL = 12'h4E8;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h4F0;

    localparam int STS_PAR_BIT = 0;
    localparam int CTL_REP_LO = 0;
    localparam int CTL_REP_HI = 1;
    localparam int CTL_IRQ_BIT = 2;
    localparam int CNT_HI = 7;
    localparam int TO_EN_BIT = 0;
    localparam int RCTL_POST_LO = 0;
    localparam int RCTL_POST_HI = 1;
    localparam int RCTL_NP_LO = 2;
    localparam int RCTL_NP_HI = 3;
    localparam int RCTL_CPL_LO = 4;
    localparam int RCTL_CPL_HI = 5;

    localparam logic [1:0] REP_NONE = 2'h0;
    localparam logic [1:0] REP_COR = 2'h1;
    localparam logic [1:0] REP_NONFATAL = 2'h2;
    localparam logic [1:0] REP_FATAL = 2'h3;

    localparam logic [1:0] PAR_REP_RST = 2'h2;
    localparam logic IRQ_EN_RST = 1'h0;
    localparam logic TO_EN_RST = 1'h1;
    localparam logic [1:0] POST_REP_RST = 2'h2;
    localparam logic [1:0] NP_REP_RST = 2'h0;
    localparam logic [1:0] CPL_REP_RST = 2'h0;
    localparam logic MASK_RST = 1'h0;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_ONE = 8'h01;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### logic/sier_reporter.sv
/*
 * Edge reporter: raises a message request when a flag goes from zero to one
 * and its reporting field selects a message type.
 * Assumes the flag is a level in the clk_i domain.
 */
`timescale 1ns/1ps
module sier_reporter
    import sier_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flag_i,
    input wire logic [1:0] field_i,
    output logic msg_valid_o,
    output logic [1:0] msg_type_o
);

    logic prev_q;
    logic rise_w;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= flag_i;
        end
    end

    // Only the zero-to-one change of the flag makes a message.
    assign rise_w = flag_i & ~prev_q;
    assign msg_valid_o = rise_w & (field_i != REP_NONE);
    assign msg_type_o = field_i;

endmodule

// ### testbench/sier_root_model.sv
/*
 * Root-side model that receives error messages and interrupt TLPs.
 * Assumes each message or interrupt arrives as a one-cycle pulse in clk_i.
 */
`timescale 1ns/1ps
module sier_root_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic err_cor_i,
    input wire logic err_nonfatal_i,
    input wire logic err_fatal_i,
    input wire logic int_tlp_i,
    output logic [7:0] cor_cnt_o,
    output logic [7:0] nf_cnt_o,
    output logic [7:0] fatal_cnt_o,
    output logic [7:0] int_cnt_o
);
    // Counts every message received, one per pulse cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cor_cnt_o <= 8'h00;
            nf_cnt_o <= 8'h00;
            fatal_cnt_o <= 8'h00;
            int_cnt_o <= 8'h00;
        end else begin
            cor_cnt_o <= cor_cnt_o + {7'h00, err_cor_i};
            nf_cnt_o <= nf_cnt_o + {7'h00, err_nonfatal_i};
            fatal_cnt_o <= fatal_cnt_o + {7'h00, err_fatal_i};
            int_cnt_o <= int_cnt_o + {7'h00, int_tlp_i};
        end
    end
endmodule

// ### testbench/tb_sier_regs.sv
/*
 * Self-checking testbench for the internal error register bank.
 * Assumes the root-side model counts message pulses.
 */
`timescale 1ns/1ps
module tb_sier_regs
    import sier_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic parity_err = 1'b0, up_int_en = 1'b0, expired = 1'b0;
    logic [2:0] to_sts = 3'h0;
    logic discard, int_tlp, e_cor, e_nf, e_fat, irq;
    logic [7:0] c_cor, c_nf, c_fat, c_int;
    int n_fail = 0, cmp_count = 0;
    logic [7:0] ec = 8'h00, en = 8'h00, ef = 8'h00, ei = 8'h00;

    always #4 clk_i = ~clk_i;

    sier_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .parity_err_i(parity_err), .timeout_status_i(to_sts), .upstream_int_en_i(up_int_en),
        .queue_head_expired_i(expired), .discard_tlp_o(discard), .int_tlp_o(int_tlp), .err_cor_o(e_cor),
        .err_nonfatal_o(e_nf), .err_fatal_o(e_fat), .irq_o(irq));

    sier_root_model root_u (.clk_i(clk_i), .rst_i(rst_i), .err_cor_i(e_cor), .err_nonfatal_i(e_nf),
        .err_fatal_i(e_fat), .int_tlp_i(int_tlp), .cor_cnt_o(c_cor), .nf_cnt_o(c_nf),
        .fatal_cnt_o(c_fat), .int_cnt_o(c_int));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hs, w_hs, b_hs, done;
        done = 1'b0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk_i);
            aw_hs = awvalid & awready;
            w_hs = wvalid & wready;
            b_hs = bready & bvalid;
            if (b_hs) chk({30'h0, bresp}, {30'h0, er});
            @(posedge clk_i);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) chk(32'h0, 32'h1);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_hs, done;
        done = 1'b0;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk_i);
            ar_hs = arvalid & arready;
            if (rready && rvalid) begin
                chk(rdata, ed);
                chk({30'h0, rresp}, {30'h0, er});
                done = 1'b1;
            end
            @(posedge clk_i);
            if (ar_hs) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) chk(32'h0, 32'h1);
    endtask

    task automatic pulse_par();
        @(posedge clk_i);
        parity_err <= 1'b1;
        @(posedge clk_i);
        parity_err <= 1'b0;
    endtask

    task automatic chk_msgs();
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk({c_cor, c_nf, c_fat, c_int}, {ec, en, ef, ei});
    endtask

    initial begin
        #(8 * 20000);
        n_fail++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(OFF_ERR_STS, 32'h0, RESP_OKAY);
        rd_chk(OFF_ERR_CTL, 32'h2, RESP_OKAY);
        rd_chk(OFF_ERR_CNT, 32'h0, RESP_OKAY);
        rd_chk(OFF_TO_CTL, 32'h1, RESP_OKAY);
        rd_chk(OFF_TO_RCTL, 32'h2, RESP_OKAY);
        rd_chk(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
        rd_chk(12'h4F4, 32'h0, RESP_SLVERR);
        axi_wr(12'h4F4, 32'hFFFF_FFFF, RESP_SLVERR);
        $display("test reset_values done");

        pulse_par();
        en++;
        chk_msgs();
        rd_chk(OFF_ERR_STS, 32'h1, RESP_OKAY);
        pulse_par();
        chk_msgs();
        rd_chk(OFF_ERR_CNT, 32'h2, RESP_OKAY);
        rd_chk(OFF_ERR_CNT, 32'h0, RESP_OKAY);
        axi_wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
        @(negedge clk_i);
        chk({31'h0, irq}, 32'h1);
        axi_wr(OFF_ERR_STS, 32'hFFFF_FFFF, RESP_OKAY);
        @(negedge clk_i);
        chk({31'h0, irq}, 32'h0);
        rd_chk(OFF_ERR_STS, 32'h0, RESP_OKAY);
        $display("test parity_flag done");

        up_int_en <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            axi_wr(OFF_ERR_CTL, 32'h4 | k, RESP_OKAY);
            pulse_par();
            if (k == 1) ec++;
            if (k == 2) en++;
            if (k == 3) ef++;
            ei++;
            chk_msgs();
            axi_wr(OFF_ERR_STS, 32'h1, RESP_OKAY);
        end
        up_int_en <= 1'b0;
        pulse_par();
        ef++;
        chk_msgs();
        $display("test parity_report done");

        axi_wr(OFF_ERR_CTL, 32'hFFFF_FFFF, RESP_OKAY);
        rd_chk(OFF_ERR_CTL, 32'h7, RESP_OKAY);
        axi_wr(OFF_ERR_CTL, 32'h0, RESP_OKAY);
        rd_chk(OFF_ERR_CNT, 32'h5, RESP_OKAY);
        repeat (260) pulse_par();
        rd_chk(OFF_ERR_CNT, 32'hFF, RESP_OKAY);
        rd_chk(OFF_ERR_CNT, 32'h0, RESP_OKAY);
        chk_msgs();
        $display("test counter done");

        expired <= 1'b1;
        @(negedge clk_i);
        chk({31'h0, discard}, 32'h1);
        axi_wr(OFF_TO_CTL, 32'h0, RESP_OKAY);
        @(negedge clk_i);
        chk({31'h0, discard}, 32'h0);
        axi_wr(OFF_TO_CTL, 32'h1, RESP_OKAY);
        expired <= 1'b0;
        axi_wr(OFF_TO_RCTL, 32'h1B, RESP_OKAY);
        rd_chk(OFF_TO_RCTL, 32'h1B, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            to_sts[i] <= 1'b1;
            if (i == 0) ef++;
            if (i == 1) en++;
            if (i == 2) ec++;
            chk_msgs();
        end
        chk_msgs();
        @(posedge clk_i);
        to_sts <= 3'h0;
        axi_wr(OFF_TO_RCTL, 32'h0, RESP_OKAY);
        to_sts <= 3'h7;
        chk_msgs();
        $display("test timeout done");
        report_and_stop();
    end
endmodule
